// File: rtl/ntbm_map_table.sv
// requester map tables, table access port and forward lookup for both bridge sides
`timescale 1ns/1ps
`default_nettype none
module ntbm_map_table #(
  parameter int ENTRIES = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wr_be,
  input wire logic wr_stb,
  input wire logic [3:0] rd_be,
  input wire logic rd_stb,
  output logic [31:0] rd_data,
  input wire ntbm_pkg::ntbm_req_s [1:0] req_in,
  output ntbm_pkg::ntbm_rsp_s [1:0] rsp_out,
  input wire logic [7:0] port_c_link_pin
);
  if (ENTRIES != ntbm_pkg::ENTRY_CNT) begin : g_chk
    $error("ntbm_map_table: ENTRIES must be 16 to match the 4-bit index");
  end

  // ====================================================================
  // helpers
  function automatic logic reg_hit(input logic [7:0] a, input logic s, input logic [7:0] ofs);
    return a == ((s ? ntbm_pkg::SIDE_STRIDE : 8'h00) + ofs);
  endfunction : reg_hit

  // an invalid entry answers zero without looking at storage
  function automatic logic [31:0] entry_word(input logic v, input logic [15:0] f);
    return v ? {f, 15'h0000, 1'b1} : 32'h0000_0000;
  endfunction : entry_word

  // ====================================================================
  // state
  logic [1:0][ntbm_pkg::IDX_W-1:0] idx_reg, idx_next;
  logic [1:0][1:0] sts_reg, sts_next;
  logic [1:0][15:0] ctrl_reg, ctrl_next;
  logic [1:0][15:0] vld_reg, vld_next;
  logic [31:0] rd_data_next;
  ntbm_pkg::ntbm_rsp_s [1:0] rsp_next;
  logic [7:0] link_meta_reg, link_sync_reg;
  logic [15:0] tbl_mem [2][16];
  logic tbl_we;
  logic tbl_ws;
  logic [ntbm_pkg::IDX_W-1:0] tbl_wi;
  logic [15:0] tbl_wd;
  logic cfg_done;
  logic link_up;

  // either side's configured bit opens the bridge; whichever root finishes first enables it
  assign cfg_done = ctrl_reg[0][ntbm_pkg::CTRL_CFG_BIT] | ctrl_reg[1][ntbm_pkg::CTRL_CFG_BIT];
  assign link_up = link_sync_reg[ntbm_pkg::LINK_UP_BIT];

  // ====================================================================
  // register access and lookup
  always_comb begin
    logic [ntbm_pkg::IDX_W-1:0] cur;
    logic dacc;
    logic hit;
    logic [ntbm_pkg::IDX_W-1:0] hidx;
    idx_next = idx_reg;
    sts_next = sts_reg;
    ctrl_next = ctrl_reg;
    vld_next = vld_reg;
    rd_data_next = 32'h0000_0000;
    rsp_next = '0;
    tbl_we = 1'b0;
    tbl_ws = 1'b0;
    tbl_wi = '0;
    tbl_wd = 16'h0000;
    cur = '0;
    dacc = 1'b0;
    hit = 1'b0;
    hidx = '0;
    for (int s = 0; s < 2; s++) begin
      cur = idx_reg[s];
      // index field is the low nibble, entries 0..15
      if (wr_stb && wr_be[0] && reg_hit(addr, s[0], ntbm_pkg::OFS_INDEX)) begin
        idx_next[s] = wdata[ntbm_pkg::IDX_W-1:0];
      end
      if (rd_stb && reg_hit(addr, s[0], ntbm_pkg::OFS_INDEX)) begin
        rd_data_next = {28'h000_0000, cur};
      end
      if (wr_stb && reg_hit(addr, s[0], ntbm_pkg::OFS_CTRL)) begin
        if (wr_be[0]) begin
          ctrl_next[s][7:0] = wdata[7:0];
        end
        if (wr_be[1]) begin
          ctrl_next[s][15:8] = wdata[15:8];
        end
      end
      if (rd_stb && reg_hit(addr, s[0], ntbm_pkg::OFS_CTRL)) begin
        rd_data_next = {16'h0000, ctrl_reg[s]};
      end
      if (rd_stb && reg_hit(addr, s[0], ntbm_pkg::OFS_LINK)) begin
        // internal end sees the on-chip link, external end mirrors port C
        rd_data_next = {24'h00_0000, s == 0 ? ntbm_pkg::VIRT_LINK_STS : link_sync_reg};
      end
      // status is write-one-to-clear; events below set after the clear
      if (wr_stb && wr_be[0] && reg_hit(addr, s[0], ntbm_pkg::OFS_STATUS)) begin
        sts_next[s] = sts_reg[s] & ~wdata[1:0];
      end
      if (rd_stb && reg_hit(addr, s[0], ntbm_pkg::OFS_STATUS)) begin
        rd_data_next = {30'h0000_0000, sts_reg[s]};
      end
      dacc = (wr_stb || rd_stb) && reg_hit(addr, s[0], ntbm_pkg::OFS_DATA);
      if (dacc) begin
        if ((wr_stb ? wr_be : rd_be) != ntbm_pkg::FULL_BE) begin
          sts_next[s][ntbm_pkg::STS_ACCERR_BIT] = 1'b1;
        end else if (wr_stb) begin
          tbl_we = 1'b1;
          tbl_ws = s[0];
          tbl_wi = cur;
          tbl_wd = wdata[ntbm_pkg::BUS_HI:ntbm_pkg::FUNC_LO];
          vld_next[s][cur] = wdata[ntbm_pkg::VALID_BIT];
        end else begin
          rd_data_next = entry_word(vld_reg[s][cur], tbl_mem[s][cur]);
        end
      end
      // associative lookup; the lowest matching valid entry wins
      hit = 1'b0;
      hidx = '0;
      for (int k = ntbm_pkg::ENTRY_CNT - 1; k >= 0; k--) begin
        if (vld_reg[s][k] && tbl_mem[s][k] == req_in[s].rid) begin
          hit = 1'b1;
          hidx = k[ntbm_pkg::IDX_W-1:0];
        end
      end
      if (req_in[s].vld) begin
        if (req_in[s].is_msg) begin
          rsp_next[s].drop = 1'b1;
        end else if (!req_in[s].bar_hit || !cfg_done) begin
          rsp_next[s].ur = 1'b1;
        // a request toward a dead port C link counts as a miss, so the sender gets an answer
        end else if (!hit || (s == 0 && !link_up)) begin
          rsp_next[s].ur = 1'b1;
          sts_next[s][ntbm_pkg::STS_MISS_BIT] = 1'b1;
        end else begin
          rsp_next[s].fwd = 1'b1;
          // device and function carry the entry index so a completion can find its way back
          rsp_next[s].rid = {ctrl_reg[1-s][15:ntbm_pkg::CTRL_BUS_LO], 4'h0, hidx};
        end
      end
    end
    if (rd_stb && addr == ntbm_pkg::OFS_IDENT) begin
      rd_data_next = {8'h00, ntbm_pkg::NT_PORT_NUM, ntbm_pkg::CFG_SPACE_KB, ntbm_pkg::HDR_TYPE1};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idx_reg <= {2{ntbm_pkg::IDX_RST}};
      sts_reg <= {2{ntbm_pkg::STS_RST}};
      ctrl_reg <= {2{ntbm_pkg::CTRL_RST}};
      vld_reg <= '0;
      rd_data <= 32'h0000_0000;
      rsp_out <= '0;
    end else begin
      idx_reg <= idx_next;
      sts_reg <= sts_next;
      ctrl_reg <= ctrl_next;
      vld_reg <= vld_next;
      rd_data <= rd_data_next;
      rsp_out <= rsp_next;
    end
  end

  // storage has no reset; only the valid flags are cleared
  always_ff @(posedge core_clk) begin
    if (tbl_we) begin
      tbl_mem[tbl_ws][tbl_wi] <= tbl_wd;
    end
  end

  // ====================================================================
  // port C link status synchroniser
  // the pin moves with no regard to core_clk, so logic reads only the second stage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link_meta_reg <= 8'h00;
      link_sync_reg <= 8'h00;
    end else begin
      link_meta_reg <= port_c_link_pin;
      link_sync_reg <= link_meta_reg;
    end
  end

  // ====================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  partial_err_set_a: assert property (
    (wr_stb || rd_stb) && addr == ntbm_pkg::OFS_DATA && (wr_stb ? wr_be : rd_be) != ntbm_pkg::FULL_BE
    |=> sts_reg[0][ntbm_pkg::STS_ACCERR_BIT]) else $error("partial access did not set error flag");
  partial_no_write_a: assert property (
    wr_stb && addr == ntbm_pkg::OFS_DATA && wr_be != ntbm_pkg::FULL_BE
    |=> vld_reg[0] == $past(vld_reg[0]) && rd_data == 32'h0000_0000) else $error("partial write changed table");
  invalid_read_zero_a: assert property (
    rd_stb && rd_be == ntbm_pkg::FULL_BE && addr == ntbm_pkg::OFS_DATA && !vld_reg[0][idx_reg[0]]
    |=> rd_data == 32'h0000_0000) else $error("invalid entry read nonzero");
  msg_dropped_a: assert property (
    req_in[1].vld && req_in[1].is_msg |=> rsp_out[1].drop && !rsp_out[1].fwd && !rsp_out[1].ur)
    else $error("message not silently dropped");
  miss_flag_set_a: assert property (
    rsp_out[1].ur && !$past(req_in[1].is_msg) && $past(req_in[1].bar_hit) && $past(cfg_done)
    |-> sts_reg[1][ntbm_pkg::STS_MISS_BIT]) else $error("miss flag not set");
  unconfigured_hold_a: assert property (
    !cfg_done ##1 !cfg_done |-> !rsp_out[0].fwd && !rsp_out[1].fwd) else $error("forward before configuration");
  forward_rid_a: assert property (
    req_in[0].vld ##1 rsp_out[0].fwd
    |-> rsp_out[0].rid[15:8] == $past(ctrl_reg[1][15:8])) else $error("forwarded bus number wrong");
  ext_link_mirror_a: assert property (
    rd_stb && addr == (ntbm_pkg::SIDE_STRIDE + ntbm_pkg::OFS_LINK)
    |=> rd_data[7:0] == $past(link_sync_reg)) else $error("external link status not mirrored");
  index_select_a: assert property (
    wr_stb && wr_be[0] && addr == ntbm_pkg::OFS_INDEX ##1 rd_stb && addr == ntbm_pkg::OFS_INDEX
    |=> rd_data[3:0] == $past(wdata[3:0], 2)) else $error("index register did not take value");

  // ====================================================================
  // lookup answers on both sides
  int_msg_dropped_a: assert property (
    req_in[0].vld && req_in[0].is_msg
    |=> rsp_out[0].drop && !rsp_out[0].fwd && !rsp_out[0].ur) else $error("internal message not dropped");
  int_rsp_onehot_a: assert property (
    req_in[0].vld
    |=> $onehot({rsp_out[0].fwd, rsp_out[0].ur, rsp_out[0].drop})) else $error("internal answer not one-hot");
  ext_rsp_onehot_a: assert property (
    req_in[1].vld
    |=> $onehot({rsp_out[1].fwd, rsp_out[1].ur, rsp_out[1].drop})) else $error("external answer not one-hot");
  int_rsp_idle_a: assert property (
    !req_in[0].vld
    |=> rsp_out[0] == '0) else $error("internal answer without request");
  ext_rsp_idle_a: assert property (
    !req_in[1].vld
    |=> rsp_out[1] == '0) else $error("external answer without request");
  int_msg_quiet_a: assert property (
    req_in[0].vld && req_in[0].is_msg && !sts_reg[0][ntbm_pkg::STS_MISS_BIT]
    |=> !sts_reg[0][ntbm_pkg::STS_MISS_BIT]) else $error("message raised internal miss flag");
  ext_msg_quiet_a: assert property (
    req_in[1].vld && req_in[1].is_msg && !sts_reg[1][ntbm_pkg::STS_MISS_BIT]
    |=> !sts_reg[1][ntbm_pkg::STS_MISS_BIT]) else $error("message raised external miss flag");
  int_unconf_ur_a: assert property (
    req_in[0].vld && !req_in[0].is_msg && !cfg_done
    |=> rsp_out[0].ur && !rsp_out[0].fwd) else $error("unconfigured request not refused");
  link_down_miss_a: assert property (
    req_in[0].vld && !req_in[0].is_msg && req_in[0].bar_hit && cfg_done && !link_up
    |=> rsp_out[0].ur && sts_reg[0][ntbm_pkg::STS_MISS_BIT]) else $error("link down request not a miss");

  // ====================================================================
  // register port answers
  rd_idle_zero_a: assert property (
    !rd_stb
    |=> rd_data == 32'h0000_0000) else $error("read data outside read cycle");
  ext_partial_err_a: assert property (
    (wr_stb || rd_stb) && addr == (ntbm_pkg::SIDE_STRIDE + ntbm_pkg::OFS_DATA)
    && (wr_stb ? wr_be : rd_be) != ntbm_pkg::FULL_BE
    |=> sts_reg[1][ntbm_pkg::STS_ACCERR_BIT]) else $error("external partial access did not set error flag");
  full_write_only_a: assert property (
    tbl_we
    |-> wr_stb && wr_be == ntbm_pkg::FULL_BE) else $error("table written by partial access");
  idx_hold_a: assert property (
    !wr_stb
    |=> idx_reg == $past(idx_reg)) else $error("index changed without write");
  index_upper_zero_a: assert property (
    rd_stb && addr == ntbm_pkg::OFS_INDEX
    |=> rd_data[31:4] == 28'h000_0000) else $error("index upper bits not zero");
  valid_readback_a: assert property (
    rd_stb && rd_be == ntbm_pkg::FULL_BE && addr == ntbm_pkg::OFS_DATA && vld_reg[0][idx_reg[0]]
    |=> rd_data[ntbm_pkg::VALID_BIT]) else $error("valid entry read without valid bit");
  reserved_zero_a: assert property (
    rd_stb && addr == ntbm_pkg::OFS_DATA
    |=> rd_data[15:1] == 15'h0000) else $error("reserved entry bits not zero");
  int_link_virtual_a: assert property (
    rd_stb && addr == ntbm_pkg::OFS_LINK
    |=> rd_data == {24'h00_0000, ntbm_pkg::VIRT_LINK_STS}) else $error("internal link status wrong");
  ident_layout_a: assert property (
    rd_stb && addr == ntbm_pkg::OFS_IDENT
    |=> rd_data[15:0] == {ntbm_pkg::CFG_SPACE_KB, ntbm_pkg::HDR_TYPE1}) else $error("ident layout wrong");
endmodule : ntbm_map_table
`default_nettype wire

// File: rtl/ntbm_pkg.sv
// package: register map, entry layout and carriers for the requester map tables
package ntbm_pkg;
  localparam int ENTRY_CNT = 16;
  localparam int IDX_W = 4;
  localparam int ADDR_W = 8;
  // ====================================================================
  // register map (byte addresses); the external side sits one stride up
  localparam logic [7:0] OFS_INDEX = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_LINK = 8'h10;
  localparam logic [7:0] SIDE_STRIDE = 8'h20;
  localparam logic [7:0] OFS_IDENT = 8'h40;
  // ====================================================================
  // entry layout
  localparam int BUS_HI = 31;
  localparam int BUS_LO = 24;
  localparam int DEV_HI = 23;
  localparam int DEV_LO = 19;
  localparam int FUNC_HI = 18;
  localparam int FUNC_LO = 16;
  localparam int VALID_BIT = 0;
  // ====================================================================
  // status, control and link fields
  localparam int STS_ACCERR_BIT = 0;
  localparam int STS_MISS_BIT = 1;
  localparam int CTRL_CFG_BIT = 0;
  localparam int CTRL_BUS_LO = 8;
  localparam int LINK_UP_BIT = 0;
  localparam logic [3:0] FULL_BE = 4'hF;
  localparam logic [IDX_W-1:0] IDX_RST = 4'h0;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [1:0] STS_RST = 2'h0;
  localparam logic [7:0] VIRT_LINK_STS = 8'h11;
  localparam logic [7:0] HDR_TYPE1 = 8'h01;
  localparam logic [7:0] CFG_SPACE_KB = 8'h04;
  localparam logic [7:0] NT_PORT_NUM = 8'h02;
  // ====================================================================
  // carriers
  typedef struct packed {
    logic vld;
    logic is_msg;
    logic bar_hit;
    logic [15:0] rid;
  } ntbm_req_s;
  typedef struct packed {
    logic fwd;
    logic ur;
    logic drop;
    logic [15:0] rid;
  } ntbm_rsp_s;
endpackage : ntbm_pkg

// File: rtl/ntbm_fix_note_unused.sv
// intentionally empty compile unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: dv/ntbm_root_model.sv
// far-side requester model: one request per call on a chosen bridge side
`timescale 1ns/1ps
`default_nettype none
module ntbm_root_model (
  input wire logic core_clk,
  output var ntbm_pkg::ntbm_req_s [1:0] req_in,
  input wire ntbm_pkg::ntbm_rsp_s [1:0] rsp_out
);
  initial req_in = '0;
  // ====================================================================
  // request issue
  task automatic send(input int s, input logic msg, input logic hit, input logic [15:0] rid,
                      output ntbm_pkg::ntbm_rsp_s r);
    @(posedge core_clk);
    req_in[s] <= '{vld: 1'b1, is_msg: msg, bar_hit: hit, rid: rid};
    @(posedge core_clk);
    // released fields are scrambled so nothing leans on stale values
    req_in[s] <= '{vld: 1'b0, is_msg: ~msg, bar_hit: ~hit, rid: ~rid};
    #1 r = rsp_out[s];
  endtask : send
endmodule : ntbm_root_model
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the requester map tables
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wr_be = 4'h0;
  logic [3:0] rd_be = 4'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rd_data;
  logic [7:0] port_c_link_pin = 8'h00;
  ntbm_pkg::ntbm_req_s [1:0] req_in;
  ntbm_pkg::ntbm_rsp_s [1:0] rsp_out;
  int errors = 0;
  int n_checks = 0;
  logic [31:0] lfsr = 32'he005_c242;
  always #5 core_clk = ~core_clk;
  ntbm_map_table #(.ENTRIES(16)) dut (.core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_be(wr_be), .wr_stb(wr_stb), .rd_be(rd_be), .rd_stb(rd_stb), .rd_data(rd_data),
    .req_in(req_in), .rsp_out(rsp_out), .port_c_link_pin(port_c_link_pin));
  ntbm_root_model root (.core_clk(core_clk), .req_in(req_in), .rsp_out(rsp_out));
  // ====================================================================
  // helpers
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  // invalid entries read zero, reserved bits read zero
  function automatic logic [31:0] exp_entry(input logic [31:0] d);
    return d[0] ? (d & 32'hFFFF_0001) : 32'h0000_0000;
  endfunction : exp_entry
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_be <= be;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [3:0] be, input logic [31:0] e, input string nm);
    @(posedge core_clk);
    addr <= a;
    rd_be <= be;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 chk(nm, e, rd_data);
  endtask : rdc
  task automatic look(input int s, input logic msg, input logic [15:0] rid, input logic [2:0] fl,
                      input logic [15:0] erid);
    ntbm_pkg::ntbm_rsp_s r;
    root.send(s, msg, 1'b1, rid, r);
    chk("rsp flags", {29'h0, fl}, {29'h0, r.fwd, r.ur, r.drop});
    if (fl == 3'b100) chk("rsp rid", {16'h0, erid}, {16'h0, r.rid});
  endtask : look
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    wrap_up();
  end
  // ====================================================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [7:0] b;
    logic [15:0] rid;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    port_c_link_pin <= 8'hA5;
    for (int s = 0; s < 2; s++) begin
      b = 8'(s * 32);
      for (int i = 0; i < 16; i++) begin
        wr(b, 32'(i), 4'hF);
        rdc(b + 8'h04, 4'hF, 32'h0, "entry after reset");
      end
      rdc(b + 8'h08, 4'hF, 32'h0, "status after reset");
      rdc(b + 8'h0C, 4'hF, 32'h0, "control after reset");
    end
    rdc(8'h40, 4'hF, 32'h0002_0401, "ident");
    rdc(8'h10, 4'hF, 32'h0000_0011, "internal link");
    rdc(8'h30, 4'hF, 32'h0000_00A5, "external link");
    rdc(8'h7C, 4'hF, 32'h0, "unmapped");
    $display("test reset done");
    for (int k = 0; k < 12; k++) begin
      b = k[0] ? 8'h20 : 8'h00;
      d = rnd();
      d[0] = k[1];
      wr(b, {28'h0, d[7:4]}, 4'hF);
      wr(b + 8'h04, d, 4'hF);
      rdc(b + 8'h04, 4'hF, exp_entry(d), "entry readback");
    end
    // back-to-back index write and read, upper write bits must be ignored
    @(posedge core_clk);
    addr <= 8'h00;
    wdata <= rnd();
    wr_be <= 4'hF;
    wr_stb <= 1'b1;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    rd_be <= 4'hF;
    rd_stb <= 1'b1;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1 chk("index readback", {28'h000_0000, wdata[3:0]}, rd_data);
    $display("test entries done");
    d = rnd() | 32'h0000_0001;
    wr(8'h00, 32'h5, 4'hF);
    wr(8'h04, d, 4'hF);
    wr(8'h04, ~d, 4'h3);
    rdc(8'h04, 4'hF, exp_entry(d), "entry after partial write");
    rdc(8'h08, 4'hF, 32'h1, "access error");
    wr(8'h08, 32'h1, 4'hF);
    rdc(8'h04, 4'h1, 32'h0, "partial read");
    rdc(8'h08, 4'hF, 32'h1, "access error");
    wr(8'h08, 32'h1, 4'hF);
    rdc(8'h24, 4'hC, 32'h0, "external partial read");
    rdc(8'h28, 4'hF, 32'h1, "external access error");
    wr(8'h28, 32'h1, 4'hF);
    $display("test partial done");
    rid = {8'h3C, 5'h11, 3'h5};
    wr(8'h00, 32'hE, 4'hF);
    wr(8'h04, {rid, 16'h0001}, 4'hF);
    look(0, 1'b0, rid, 3'b010, 16'h0);
    wr(8'h0C, 32'h0000_0701, 4'hF);
    wr(8'h2C, 32'h0000_5A01, 4'hF);
    look(0, 1'b1, rid, 3'b001, 16'h0);
    look(1, 1'b1, rid, 3'b001, 16'h0);
    rdc(8'h08, 4'hF, 32'h0, "status after message");
    look(0, 1'b0, rid, 3'b100, 16'h5A0E);
    look(1, 1'b0, rid, 3'b010, 16'h0);
    rdc(8'h28, 4'hF, 32'h2, "external miss");
    port_c_link_pin <= 8'h00;
    repeat (4) @(posedge core_clk);
    look(0, 1'b0, rid, 3'b010, 16'h0);
    rdc(8'h08, 4'hF, 32'h2, "internal miss");
    $display("test lookup done");
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    wr(8'h00, 32'hE, 4'hF);
    rdc(8'h04, 4'hF, 32'h0, "entry after second reset");
    rdc(8'h08, 4'hF, 32'h0, "status after second reset");
    $display("test second reset done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
